//--- design/pdio_pkg.sv
// pdio_pkg: constants, encodings and state types shared by both ends of the pmic digital i/o link.
// assumes one 40 MHz clock in every module that imports it.
package pdio_pkg;
   // clock and slow timebase
   localparam int CLK_MHZ = 40;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES_DFLT = TICK_US * CLK_MHZ;
   // times in their printed units
   localparam int PH_GF_US = 100;
   localparam int DBNC_ONKEY_MS = 30;
   localparam int DBNC_GPI_MS = 30;
   localparam int MRST_MS = 16000;
   localparam int HOLD_WAIT_MS = 1000;
   localparam int SEQ_STEP_MS = 2;
   localparam int RST_DEASSERT_MS = 4;
   localparam int RST_ASSERT_MS = 2;
   // derived counts (cycles for the glitch filter, ticks for the rest)
   localparam logic [15:0] PH_GF_CYCLES = 16'(PH_GF_US * CLK_MHZ);
   localparam logic [15:0] DBNC_ONKEY_TICKS = 16'(DBNC_ONKEY_MS * 1000 / TICK_US);
   localparam logic [15:0] DBNC_GPI_TICKS = 16'(DBNC_GPI_MS * 1000 / TICK_US);
   localparam logic [15:0] MRST_TICKS = 16'(MRST_MS * 1000 / TICK_US);
   localparam logic [15:0] HOLD_WAIT_TICKS = 16'(HOLD_WAIT_MS * 1000 / TICK_US);
   localparam logic [15:0] SEQ_STEP_TICKS = 16'(SEQ_STEP_MS * 1000 / TICK_US);
   localparam logic [15:0] RST_DEASSERT_TICKS = 16'(RST_DEASSERT_MS * 1000 / TICK_US);
   localparam logic [15:0] RST_ASSERT_TICKS = 16'(RST_ASSERT_MS * 1000 / TICK_US);
   // regulator chain
   localparam int NREG = 4;
   localparam logic [1:0] REG_LAST = 2'h3;
   localparam logic [1:0] REG_FIRST = 2'h0;
   // pin indices in synchroniser arrays
   localparam int PIN_ONKEY = 0;
   localparam int PIN_HOLD = 1;
   localparam int PIN_GPIO = 2;
   localparam int PIN_IRQ = 0;
   localparam int PIN_RST = 1;
   // device configuration port
   localparam logic [1:0] CFG_CTRL = 2'h0;
   localparam logic [1:0] CFG_MASK = 2'h1;
   localparam logic [1:0] CFG_GPIO = 2'h2;
   localparam logic [1:0] CFG_INTCLR = 2'h3;
   localparam int CTRL_SWITCH_TYPE = 0;
   localparam int CTRL_COLD_RESTART = 1;
   localparam int CTRL_POWER_OFF = 2;
   localparam int GPIO_DIR = 0;
   localparam int GPIO_DRV = 1;
   localparam int GPIO_OUT = 2;
   localparam int GPIO_DEB = 3;
   // interrupt flag positions
   localparam int INT_ONKEY_RISE = 0;
   localparam int INT_ONKEY_FALL = 1;
   localparam int INT_GPI_RISE = 2;
   localparam int INT_GPI_FALL = 3;
   // reset values
   localparam logic [3:0] MASK_RST = 4'hF;
   localparam logic SWITCH_TYPE_RST = 1'b0;
   localparam logic [8:0] DEV_SYN_RST = 9'h1C7;
   localparam logic [2:0] DEV_CL_RST = 3'h5;
   localparam logic [8:0] HOST_SYN_RST = 9'h1FF;
   // host avalon register map (byte addresses)
   localparam logic [3:0] HOST_CTRL = 4'h0;
   localparam logic [3:0] HOST_STAT = 4'h4;
   localparam int HCTL_HOLD = 0;
   localparam int HCTL_GPIO_OUT = 1;
   localparam int HCTL_GPIO_OE = 2;

   typedef enum logic [2:0] {
      ST_STANDBY = 3'b000,
      ST_UP = 3'b001,
      ST_RSTDLY = 3'b010,
      ST_HWAIT = 3'b011,
      ST_ON = 3'b100,
      ST_PRE = 3'b101,
      ST_DOWN = 3'b110
   } pdio_state_e;
endpackage

//--- design/pdio_if.sv
// pdio_if: the board wires between the pmic digital i/o and its host processor.
// assumes external pullups on the interrupt, reset and gpio nets; enables pull them low or drive them.
`timescale 1ns/1ps
`default_nettype none
interface pdio_if;
   logic power_hold_in;
   logic irq_oe;
   logic rst_oe;
   logic gdev_o;
   logic gdev_oe;
   logic ghost_o;
   logic ghost_oe;
   logic irq_out_n;
   logic reset_out_n;
   logic gpio_level;
   // open-drain nets read high unless someone pulls them down
   assign irq_out_n = ~irq_oe;
   assign reset_out_n = ~rst_oe;
   assign gpio_level = gdev_oe ? gdev_o : (ghost_oe ? ghost_o : 1'b1);
   modport dev (input power_hold_in, input gpio_level, output irq_oe, output rst_oe, output gdev_o, output gdev_oe);
   modport host (input irq_out_n, input reset_out_n, input gpio_level, output power_hold_in, output ghost_o,
      output ghost_oe);
endinterface
`default_nettype wire

//--- design/pdio_device.sv
// pdio_device: on-key, power-hold, reset output, interrupt output and gpio logic of the pmic.
// assumes pins from pdio_if.dev, a config write port from the pmic's own register logic,
// and a host that keeps its own side of the power-hold protocol.
//
// Summary of operation
// - timer oscillator runs only while a timer counts
// - switch type resets to push-button
// - host sets slide-switch type before hold time
// - unmasked recorded event asserts interrupt output
// - all masks reset masked; software unmasks
// - interrupt output active low open drain
// - reset released after last regulator plus delay
// - reset asserted before first regulator turns off
// - power-hold glitch filter rejects under 100us
// - filtered hold ORed with charger wakeup
// - hold must come within wait window
// - hold low or soft command powers down
// - valid charger keeps combined hold asserted
// - direction clear makes gpio an output
// - drive bit selects push-pull or open drain
// - input level reported in every direction
// - direction set disables all pin drivers
// - 30ms gpio debounce switchable by enable
// - bypassed debounce reaches interrupt logic fast
// - host picks debounce by source cleanliness
// - debounced on-key falling edge starts power-up
// - on-key held for hold time powers down
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pdio_device
   import pdio_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
   input wire logic clock,
   input wire logic resetn,
   pdio_if.dev pins,
   input wire logic on_key_input,
   input wire logic charge_input_valid,
   input wire logic cfg_wr,
   input wire logic [1:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [3:0] int_flags,
   output logic gpio_in_level,
   output logic onkey_level,
   output logic combined_hold,
   output logic timer_osc_on,
   output logic [NREG-1:0] reg_en,
   output logic [2:0] dev_state
);
   typedef struct packed {
      logic [2:0][2:0] syn;
      logic [2:0] cl;
      logic [15:0] div;
      logic onk_db;
      logic onk_prev;
      logic [15:0] onk_cnt;
      logic gp_db;
      logic gp_prev;
      logic [15:0] gp_cnt;
      logic ph_f;
      logic [15:0] ph_cnt;
      logic [15:0] mr_cnt;
      logic chold;
      pdio_state_e st;
      logic [15:0] tcnt;
      logic [1:0] step;
      logic [NREG-1:0] regen;
      logic rst_rel;
      logic rs_pend;
      logic [3:0] flags;
      logic [3:0] mask;
      logic swt;
      logic gdir;
      logic gdrv;
      logic gout;
      logic gdeb;
   } pdio_dev_s;

   localparam pdio_dev_s DEV_RST = '{syn: DEV_SYN_RST, cl: DEV_CL_RST, onk_db: 1'b1, onk_prev: 1'b1,
      gp_db: 1'b1, gp_prev: 1'b1, st: ST_STANDBY, mask: MASK_RST, swt: SWITCH_TYPE_RST, gdir: 1'b1, default: '0};
   localparam logic [15:0] ONE16 = 16'h0001;

   // tick count for the sequencing timer in each state
   function automatic logic [15:0] seq_limit(input pdio_state_e s);
      case (s)
         ST_RSTDLY: seq_limit = RST_DEASSERT_TICKS;
         ST_HWAIT: seq_limit = HOLD_WAIT_TICKS;
         ST_PRE: seq_limit = RST_ASSERT_TICKS;
         default: seq_limit = SEQ_STEP_TICKS;
      endcase
   endfunction

   pdio_dev_s r_r, r_nxt;
   logic [15:0] tick_max;
   logic [2:0] pin_in;
   logic onk_busy, gp_busy, mr_busy, seq_busy, osc_on, tick, tdone, held;
   logic gp_lvl, chold, mr_done, soft_cr, soft_off;
   logic [3:0] ev, clr;

   assign tick_max = 16'(TICK_CYCLES - 1);
   assign pin_in = {pins.gpio_level, pins.power_hold_in, on_key_input};

   // timer activity; the slow oscillator is gated so it costs nothing while idle
   assign onk_busy = r_r.cl[PIN_ONKEY] != r_r.onk_db;
   assign gp_busy = r_r.gdeb && (r_r.cl[PIN_GPIO] != r_r.gp_db);
   assign held = r_r.swt ? r_r.onk_db : ~r_r.onk_db;
   assign mr_busy = (r_r.st == ST_ON) && held;
   assign seq_busy = (r_r.st != ST_STANDBY) && (r_r.st != ST_ON);
   assign osc_on = onk_busy | gp_busy | mr_busy | seq_busy;
   assign tick = osc_on && (r_r.div == tick_max);
   assign tdone = tick && (r_r.tcnt == seq_limit(r_r.st) - ONE16);
   assign mr_done = mr_busy && (r_r.mr_cnt == MRST_TICKS);
   // bypass takes the synchronised level straight to the edge detectors, four cycles behind the pin
   assign gp_lvl = r_r.gdeb ? r_r.gp_db : r_r.cl[PIN_GPIO];
   assign chold = r_r.ph_f | charge_input_valid;
   assign soft_cr = cfg_wr && (cfg_addr == CFG_CTRL) && cfg_wdata[CTRL_COLD_RESTART];
   assign soft_off = cfg_wr && (cfg_addr == CFG_CTRL) && cfg_wdata[CTRL_POWER_OFF];
   assign ev[INT_ONKEY_RISE] = r_r.onk_db & ~r_r.onk_prev;
   assign ev[INT_ONKEY_FALL] = ~r_r.onk_db & r_r.onk_prev;
   assign ev[INT_GPI_RISE] = gp_lvl & ~r_r.gp_prev;
   assign ev[INT_GPI_FALL] = ~gp_lvl & r_r.gp_prev;
   assign clr = (cfg_wr && (cfg_addr == CFG_INTCLR)) ? cfg_wdata[3:0] : 4'h0;

   // next-state logic for the whole block
   always_comb begin
      r_nxt = r_r;
      // three-stage synchronisers; a level is accepted once stages two and three agree
      for (int i = 0; i < 3; i++) begin
         r_nxt.syn[i] = {r_r.syn[i][1], r_r.syn[i][0], pin_in[i]};
         r_nxt.cl[i] = (r_r.syn[i][2] == r_r.syn[i][1]) ? r_r.syn[i][2] : r_r.cl[i];
      end
      r_nxt.div = (!osc_on || tick) ? 16'h0000 : r_r.div + ONE16;
      // on-key debounce
      if (!onk_busy) begin
         r_nxt.onk_cnt = 16'h0000;
      end else if (tick) begin
         if (r_r.onk_cnt == DBNC_ONKEY_TICKS - ONE16) begin
            r_nxt.onk_db = r_r.cl[PIN_ONKEY];
            r_nxt.onk_cnt = 16'h0000;
         end else begin
            r_nxt.onk_cnt = r_r.onk_cnt + ONE16;
         end
      end
      r_nxt.onk_prev = r_r.onk_db;
      // gpio debounce, or plain follow when bypassed
      if (!r_r.gdeb) begin
         r_nxt.gp_db = r_r.cl[PIN_GPIO];
         r_nxt.gp_cnt = 16'h0000;
      end else if (!gp_busy) begin
         r_nxt.gp_cnt = 16'h0000;
      end else if (tick) begin
         if (r_r.gp_cnt == DBNC_GPI_TICKS - ONE16) begin
            r_nxt.gp_db = r_r.cl[PIN_GPIO];
            r_nxt.gp_cnt = 16'h0000;
         end else begin
            r_nxt.gp_cnt = r_r.gp_cnt + ONE16;
         end
      end
      r_nxt.gp_prev = gp_lvl;
      // power-hold glitch filter: a new level must stand a full filter time
      if (r_r.cl[PIN_HOLD] == r_r.ph_f) begin
         r_nxt.ph_cnt = 16'h0000;
      end else if (r_r.ph_cnt == PH_GF_CYCLES - ONE16) begin
         r_nxt.ph_f = r_r.cl[PIN_HOLD];
         r_nxt.ph_cnt = 16'h0000;
      end else begin
         r_nxt.ph_cnt = r_r.ph_cnt + ONE16;
      end
      r_nxt.chold = chold;
      // manual-reset hold counter
      if (!mr_busy) begin
         r_nxt.mr_cnt = 16'h0000;
      end else if (tick && (r_r.mr_cnt != MRST_TICKS)) begin
         r_nxt.mr_cnt = r_r.mr_cnt + ONE16;
      end
      // sticky flags, a new event beats a clear in the same cycle
      r_nxt.flags = (r_r.flags & ~clr) | ev;
      // configuration writes
      if (cfg_wr) begin
         case (cfg_addr)
            CFG_CTRL: r_nxt.swt = cfg_wdata[CTRL_SWITCH_TYPE];
            CFG_MASK: r_nxt.mask = cfg_wdata[3:0];
            CFG_GPIO: begin
               r_nxt.gdir = cfg_wdata[GPIO_DIR];
               r_nxt.gdrv = cfg_wdata[GPIO_DRV];
               r_nxt.gout = cfg_wdata[GPIO_OUT];
               r_nxt.gdeb = cfg_wdata[GPIO_DEB];
            end
            default: r_nxt.swt = r_r.swt;
         endcase
      end
      // power sequencer
      if (tick) begin
         r_nxt.tcnt = r_r.tcnt + ONE16;
      end
      case (r_r.st)
         ST_STANDBY: begin
            if (ev[INT_ONKEY_FALL] || r_r.rs_pend) begin
               r_nxt.st = ST_UP;
               r_nxt.step = REG_FIRST;
               r_nxt.tcnt = 16'h0000;
               r_nxt.rs_pend = 1'b0;
            end
         end
         ST_UP: begin
            if (tdone) begin
               r_nxt.regen[r_r.step] = 1'b1;
               r_nxt.tcnt = 16'h0000;
               if (r_r.step == REG_LAST) begin
                  r_nxt.st = ST_RSTDLY;
               end else begin
                  r_nxt.step = r_r.step + 2'h1;
               end
            end
         end
         ST_RSTDLY: begin
            if (tdone) begin
               r_nxt.rst_rel = 1'b1;
               r_nxt.st = ST_HWAIT;
               r_nxt.tcnt = 16'h0000;
            end
         end
         ST_HWAIT: begin
            if (chold) begin
               r_nxt.st = ST_ON;
               r_nxt.tcnt = 16'h0000;
            end else if (tdone) begin
               r_nxt.st = ST_PRE;
               r_nxt.rst_rel = 1'b0;
               r_nxt.tcnt = 16'h0000;
            end
         end
         ST_ON: begin
            if (!chold || soft_off || soft_cr || mr_done) begin
               r_nxt.st = ST_PRE;
               r_nxt.rst_rel = 1'b0;
               r_nxt.tcnt = 16'h0000;
               r_nxt.rs_pend = soft_cr;
            end
         end
         ST_PRE: begin
            if (tdone) begin
               r_nxt.st = ST_DOWN;
               r_nxt.step = REG_LAST;
               r_nxt.tcnt = 16'h0000;
            end
         end
         ST_DOWN: begin
            if (tdone) begin
               r_nxt.regen[r_r.step] = 1'b0;
               r_nxt.tcnt = 16'h0000;
               if (r_r.step == REG_FIRST) begin
                  r_nxt.st = ST_STANDBY;
               end else begin
                  r_nxt.step = r_r.step - 2'h1;
               end
            end
         end
         default: r_nxt.st = ST_STANDBY;
      endcase
   end

   // single state register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         r_r <= DEV_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   // pin drivers; open-drain outputs only ever pull low
   assign pins.irq_oe = |(r_r.flags & ~r_r.mask);
   assign pins.rst_oe = ~r_r.rst_rel;
   assign pins.gdev_oe = ~r_r.gdir & (r_r.gdrv | ~r_r.gout);
   assign pins.gdev_o = r_r.gdrv & r_r.gout;
   // status towards the pmic's register logic
   assign int_flags = r_r.flags;
   assign gpio_in_level = r_r.gp_prev;
   assign onkey_level = r_r.onk_db;
   assign combined_hold = r_r.chold;
   assign timer_osc_on = osc_on;
   assign reg_en = r_r.regen;
   assign dev_state = r_r.st;
endmodule
`default_nettype wire

//--- design/pdio_host.sv
// pdio_host: host-processor end; drives power-hold and a gpio, samples interrupt, reset and gpio.
// assumes software reaches it over avalon-mm with waitrequest, byte addresses, 32-bit words.
`timescale 1ns/1ps
`default_nettype none
module pdio_host
   import pdio_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   pdio_if.host pins,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   typedef struct packed {
      logic [2:0][2:0] syn;
      logic [2:0] cl;
      logic [2:0] ctrl;
      logic ack;
      logic [31:0] rdata;
   } pdio_host_s;

   localparam pdio_host_s HOST_RST = '{syn: HOST_SYN_RST, cl: 3'h7, default: '0};

   pdio_host_s r_r, r_nxt;
   logic [2:0] pin_in;
   logic req;

   assign pin_in = {pins.gpio_level, pins.reset_out_n, pins.irq_out_n};
   assign req = avs_read | avs_write;
   // one wait cycle per access keeps read data registered
   assign avs_waitrequest = req & ~r_r.ack;

   // next-state logic
   always_comb begin
      r_nxt = r_r;
      for (int i = 0; i < 3; i++) begin
         r_nxt.syn[i] = {r_r.syn[i][1], r_r.syn[i][0], pin_in[i]};
         r_nxt.cl[i] = (r_r.syn[i][2] == r_r.syn[i][1]) ? r_r.syn[i][2] : r_r.cl[i];
      end
      r_nxt.ack = req & ~r_r.ack;
      if (req && !r_r.ack) begin
         case (avs_address)
            HOST_CTRL: r_nxt.rdata = {29'h0, r_r.ctrl};
            HOST_STAT: r_nxt.rdata = {29'h0, r_r.cl[PIN_GPIO], ~r_r.cl[PIN_RST], ~r_r.cl[PIN_IRQ]};
            default: r_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // write lands at the edge where waitrequest is low
      if (avs_write && r_r.ack && (avs_address == HOST_CTRL)) begin
         r_nxt.ctrl = avs_writedata[2:0];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         r_r <= HOST_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign pins.power_hold_in = r_r.ctrl[HCTL_HOLD];
   assign pins.ghost_o = r_r.ctrl[HCTL_GPIO_OUT];
   assign pins.ghost_oe = r_r.ctrl[HCTL_GPIO_OE];
   assign avs_readdata = r_r.rdata;
endmodule
`default_nettype wire

//--- tb/pdio_assertions.sv
// pdio_assertions: timing relations on the pmic i/o wires and device status.
// assumes one clock domain and signals handed in by the bench top.
`timescale 1ns/1ps
`default_nettype none
module pdio_assertions
   import pdio_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic power_hold_in,
   input wire logic charge_input_valid,
   input wire logic irq_out_n,
   input wire logic reset_out_n,
   input wire logic combined_hold,
   input wire logic [3:0] int_flags,
   input wire logic [NREG-1:0] reg_en,
   input wire logic [2:0] dev_state
);
   logic [15:0] ph_cnt_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // length of the current hold-high run; saturates so it never wraps
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ph_cnt_r <= 16'h0000;
      end else if (!power_hold_in) begin
         ph_cnt_r <= 16'h0000;
      end else if (ph_cnt_r != 16'hFFFF) begin
         ph_cnt_r <= ph_cnt_r + 16'h0001;
      end
   end
   rst_release_a: assert property ($rose(reset_out_n) |-> reg_en == 4'hF)
      else $error("reset released early");
   stby_rst_a: assert property ($past(dev_state) == ST_STANDBY && dev_state == ST_STANDBY
      |-> !reset_out_n && reg_en == 4'h0) else $error("standby not quiet");
   rst_lead_a: assert property ($fell(reg_en[3]) |-> !reset_out_n && $past(!reset_out_n, 2))
      else $error("regulator off before reset");
   pre_rst_a: assert property (dev_state == ST_PRE |-> ##1 !reset_out_n)
      else $error("reset not held in pre");
   chg_hold_a: assert property (charge_input_valid ##1 charge_input_valid |-> combined_hold)
      else $error("charger not holding");
   glitch_a: assert property ($rose(combined_hold) && !charge_input_valid && !$past(charge_input_valid)
      |-> ph_cnt_r >= PH_GF_CYCLES) else $error("short hold pulse passed");
   hwait_on_a: assert property (dev_state == ST_HWAIT && combined_hold |-> ##[1:2] dev_state == ST_ON)
      else $error("hold not accepted");
   on_drop_a: assert property (dev_state == ST_ON && !combined_hold |-> ##[1:2] dev_state == ST_PRE)
      else $error("hold loss ignored");
   irq_flag_a: assert property (!irq_out_n |-> int_flags != 4'h0 || $past(int_flags) != 4'h0)
      else $error("interrupt without flag");
endmodule
`default_nettype wire

//--- tb/test_pmic_digital_io_control.sv
// test_pmic_digital_io_control: device and host ends joined over pdio_if, self-checking.
// assumes ms timers shortened with TICK_CYCLES 8; the glitch filter keeps its full length.
`timescale 1ns/1ps
`default_nettype none
module test_pmic_digital_io_control;
   import pdio_pkg::*;
   localparam int TK = 8;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic on_key_input = 1'b1;
   logic charge_input_valid = 1'b0;
   logic cfg_wr = 1'b0;
   logic [1:0] cfg_addr = 2'h0;
   logic [7:0] cfg_wdata = 8'h00;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, gpio_in_level, onkey_level, combined_hold, timer_osc_on;
   logic [3:0] int_flags, reg_en;
   logic [2:0] dev_state;
   int n_errors = 0;
   int checked = 0;
   pdio_if i_pdio_if ();
   pdio_device #(.TICK_CYCLES(TK)) i_pdio_device (.clock(clock), .resetn(resetn), .pins(i_pdio_if.dev),
      .on_key_input(on_key_input), .charge_input_valid(charge_input_valid), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .int_flags(int_flags), .gpio_in_level(gpio_in_level),
      .onkey_level(onkey_level), .combined_hold(combined_hold), .timer_osc_on(timer_osc_on),
      .reg_en(reg_en), .dev_state(dev_state));
   pdio_host i_pdio_host (.clock(clock), .resetn(resetn), .pins(i_pdio_if.host), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   pdio_assertions i_pdio_assertions (.clock(clock), .resetn(resetn),
      .power_hold_in(i_pdio_if.power_hold_in), .charge_input_valid(charge_input_valid),
      .irq_out_n(i_pdio_if.irq_out_n), .reset_out_n(i_pdio_if.reset_out_n), .combined_hold(combined_hold),
      .int_flags(int_flags), .reg_en(reg_en), .dev_state(dev_state));
   always #12.5 clock = ~clock;
   task automatic chk_bit(input logic got, input logic exp, input string m);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   // one avalon access; called just after an edge, held until waitrequest is sampled low
   task automatic avx(input logic rd, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic cfg(input logic [1:0] a, input logic [7:0] d);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clock);
      cfg_wr <= 1'b0;
      @(posedge clock);
   endtask
   // bounded wait for a controller state, then judge it
   task automatic ws(input logic [2:0] s, input int n, input string m);
      int i;
      for (i = 0; i < n && dev_state !== s; i++) @(posedge clock);
      chk_vec({1'b0, dev_state}, {1'b0, s}, m);
   endtask
   task automatic end_sim;
      $display("checked %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      chk_bit(i_pdio_if.reset_out_n, 1'b0, "reset out");
      chk_bit(i_pdio_if.irq_out_n, 1'b1, "irq idle");
      chk_vec(int_flags, 4'h0, "flags");
      chk_bit(timer_osc_on, 1'b0, "osc idle");
      avx(1'b1, HOST_STAT, 32'h0000_0000);
      chk_vec(q[3:0], 4'h6, "status");
      avx(1'b1, 4'h8, 32'h0000_0000);
      chk_vec(q[3:0], 4'h0, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_glitch;
      avx(1'b0, HOST_CTRL, 32'h0000_0001);
      repeat (3800) @(posedge clock);
      avx(1'b0, HOST_CTRL, 32'h0000_0000);
      repeat (10) @(posedge clock);
      chk_bit(combined_hold, 1'b0, "short hold");
      $display("test glitch done");
   endtask
   task automatic t_power;
      int i;
      avx(1'b0, HOST_CTRL, 32'h0000_0001);
      on_key_input <= 1'b0;
      for (i = 0; i < 1000 && reg_en !== 4'hF; i++) @(posedge clock);
      chk_bit(i_pdio_if.reset_out_n, 1'b0, "reset early");
      chk_bit(timer_osc_on, 1'b1, "osc off");
      for (i = 0; i < 1000 && i_pdio_if.reset_out_n !== 1'b1; i++) @(posedge clock);
      chk_vec(reg_en, 4'hF, "release order");
      on_key_input <= 1'b1;
      ws(ST_ON, 6000, "not on");
      chk_bit(combined_hold, 1'b1, "hold");
      charge_input_valid <= 1'b1;
      avx(1'b0, HOST_CTRL, 32'h0000_0000);
      repeat (4200) @(posedge clock);
      ws(ST_ON, 0, "charger hold");
      charge_input_valid <= 1'b0;
      ws(ST_PRE, 20, "no shutdown");
      repeat (2) @(posedge clock);
      chk_bit(i_pdio_if.reset_out_n, 1'b0, "reset lead");
      ws(ST_STANDBY, 300, "not down");
      repeat (300) @(posedge clock);
      chk_vec(reg_en, 4'h0, "regs");
      chk_bit(timer_osc_on, 1'b0, "osc left on");
      $display("test power done");
   endtask
   task automatic t_timeout;
      on_key_input <= 1'b0;
      ws(ST_HWAIT, 1000, "no wait");
      on_key_input <= 1'b1;
      repeat (7800) @(posedge clock);
      ws(ST_HWAIT, 0, "left early");
      ws(ST_PRE, 400, "no timeout");
      ws(ST_STANDBY, 300, "not down");
      $display("test timeout done");
   endtask
   task automatic t_soft;
      charge_input_valid <= 1'b1;
      on_key_input <= 1'b0;
      ws(ST_ON, 1500, "not on");
      on_key_input <= 1'b1;
      cfg(CFG_CTRL, 8'h02);
      ws(ST_PRE, 5, "restart");
      ws(ST_UP, 400, "no restart");
      ws(ST_ON, 1500, "not on");
      cfg(CFG_CTRL, 8'h04);
      ws(ST_PRE, 5, "power off");
      ws(ST_STANDBY, 300, "not down");
      charge_input_valid <= 1'b0;
      $display("test soft done");
   endtask
   task automatic t_gpio;
      int i;
      // every drive kind and output value
      for (i = 0; i < 4; i++) begin
         cfg(CFG_GPIO, {5'h00, i[0], i[1], 1'b0});
         repeat (8) @(posedge clock);
         chk_bit(i_pdio_if.gdev_oe, i[1] | ~i[0], "drive");
         chk_bit(i_pdio_if.gpio_level, i[0], "pin");
         chk_bit(gpio_in_level, i[0], "in level");
      end
      cfg(CFG_GPIO, 8'h07);
      avx(1'b0, HOST_CTRL, 32'h0000_0004);
      repeat (8) @(posedge clock);
      chk_bit(i_pdio_if.gdev_oe, 1'b0, "input drives");
      chk_bit(gpio_in_level, 1'b0, "in level");
      avx(1'b1, HOST_STAT, 32'h0000_0000);
      chk_bit(q[2], 1'b0, "stat level");
      $display("test gpio done");
   endtask
   task automatic t_irq;
      cfg(CFG_INTCLR, 8'h0F);
      cfg(CFG_MASK, 8'h07);
      avx(1'b0, HOST_CTRL, 32'h0000_0006);
      repeat (8) @(posedge clock);
      chk_bit(int_flags[2], 1'b1, "rise flag");
      chk_bit(i_pdio_if.irq_out_n, 1'b1, "masked");
      avx(1'b0, HOST_CTRL, 32'h0000_0004);
      repeat (8) @(posedge clock);
      chk_bit(i_pdio_if.irq_out_n, 1'b0, "irq");
      avx(1'b1, HOST_STAT, 32'h0000_0000);
      chk_bit(q[0], 1'b1, "stat irq");
      cfg(CFG_INTCLR, 8'h08);
      repeat (3) @(posedge clock);
      chk_bit(i_pdio_if.irq_out_n, 1'b1, "irq release");
      cfg(CFG_GPIO, 8'h09);
      avx(1'b0, HOST_CTRL, 32'h0000_0006);
      repeat (100) @(posedge clock);
      chk_bit(gpio_in_level, 1'b0, "debounce");
      repeat (300) @(posedge clock);
      chk_bit(gpio_in_level, 1'b1, "debounced");
      $display("test irq done");
   endtask
   // slide-switch on-key: a key left low while on must not start the hold timer
   task automatic t_slide;
      cfg(CFG_CTRL, 8'h01);
      charge_input_valid <= 1'b1;
      on_key_input <= 1'b0;
      ws(ST_ON, 1500, "slide not on");
      repeat (4) @(posedge clock);
      chk_bit(timer_osc_on, 1'b0, "slide hold timer");
      cfg(CFG_CTRL, 8'h05);
      ws(ST_PRE, 5, "slide off");
      ws(ST_STANDBY, 300, "slide not down");
      cfg(CFG_CTRL, 8'h00);
      on_key_input <= 1'b1;
      charge_input_valid <= 1'b0;
      $display("test slide done");
   endtask
   initial begin
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      t_reset;
      t_glitch;
      t_power;
      t_timeout;
      t_soft;
      t_gpio;
      t_irq;
      t_slide;
      end_sim;
   end
   // the whole run needs about 22000 cycles
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      end_sim;
   end
endmodule
`default_nettype wire
